// ---- pkg/cwf_regs.vh ----
/*
 register offsets, field positions, reset values and timing counts of the
 clock watchdog and frequency programming block; assumes a 25 MHz ref_clk.
*/
// Behaviour
// - watchdog time base is 290 ms with select 0, 1160 ms with 1; resets 0
// - three-bit alarm timer count resets to 111, seven time-base units
// - hard watchdog alarm returns the cpu clock to the strap frequency select
// - re-enable bit set makes leaving power down set watchdog enable; resets 0
// - two read-write increment bits, reset 0, fine-tune the cpu multiplier
// - cpu frequency is nine-bit multiplier times resolution, strap-loaded at power-on
// - src frequency is eight-bit multiplier times resolution, 100 MHz at power-on
// - clock source selection byte takes effect only after the bus stop
// - cpu mode 0 uses straps, 1 software select; alarm clears mode bit
// - src1 and pci source bits pick default sources at 0, pll2 at 1
// - increment 01 adds one third step, 10 two thirds, 00/11 nothing
// - cpu multiplier resolution is 1.0 MHz per step
// - watchdog alarm runs only while the enable bit is 1; enable resets 0
`ifndef CWF_REGS_VH
`define CWF_REGS_VH

// byte offsets
`define CWF_OFS_WD_CTRL       8'h0f
`define CWF_OFS_FINE          8'h10
`define CWF_OFS_CPU_MULT_LO   8'h11
`define CWF_OFS_SRC_MULT      8'h12
`define CWF_OFS_SRC_SEL       8'h13

// watchdog_control fields
`define CWF_WD_EN_BIT         7
`define CWF_WD_SOFT_SEL_BIT   6
`define CWF_WD_HARD_STAT_BIT  5
`define CWF_WD_SOFT_STAT_BIT  4
`define CWF_WD_TBASE_BIT      3
`define CWF_WD_TIMER_MSB      2
`define CWF_WD_RST            8'h07

// cpu_fine_and_wd_restore fields
`define CWF_FINE_REEN_BIT     7
`define CWF_FINE_IB_HI_BIT    2
`define CWF_FINE_IB_LO_BIT    1
`define CWF_FINE_TOP_BIT      0
`define CWF_FINE_RST          8'h00

// clock_source_select fields
`define CWF_SS_MODE_BIT       7
`define CWF_SS_SFS_MSB        6
`define CWF_SS_SFS_LSB        4
`define CWF_SS_NDIS_BIT       3
`define CWF_SS_SRC1_BIT       2
`define CWF_SS_PCI_BIT        1
`define CWF_SS_RST            8'h00

// frequency programming
`define CWF_SRC_MULT_RST      8'hc8
`define CWF_CPU_RES_KHZ       20'd1000
`define CWF_SRC_RES_KHZ       20'd500
`define CWF_FRAC1_KHZ         20'd333
`define CWF_FRAC2_KHZ         20'd666

// watchdog timing
`define CWF_CLK_KHZ           25000
`define CWF_WD_BASE_SHORT_MS  290
`define CWF_WD_BASE_LONG_MS   1160
`define CWF_WD_SHORT_CYC      (`CWF_WD_BASE_SHORT_MS * `CWF_CLK_KHZ)
`define CWF_WD_LONG_CYC       (`CWF_WD_BASE_LONG_MS * `CWF_CLK_KHZ)

`endif

// ---- rtl/cwf_wdog.v ----
/*
 watchdog time base and alarm timer.
 assumes enable, halt and kick are synchronous to ref_clk.
*/
`timescale 1ns/100ps
`include "cwf_regs.vh"
module cwf_wdog #(
	parameter [24:0] SHORT_CYC = `CWF_WD_SHORT_CYC,
	parameter [24:0] LONG_CYC  = `CWF_WD_LONG_CYC
) (
	// clock and reset
	input  wire       ref_clk,
	input  wire       reset_n,
	// control
	input  wire       wd_en,
	input  wire       halt,
	input  wire       kick,
	input  wire       long_base,
	input  wire       soft_sel,
	input  wire [2:0] timer_count,
	// events
	output reg        hard_pulse,
	output reg        soft_pulse
);

	reg  [24:0] base_cnt;
	reg  [2:0]  units;
	reg         fired;
	wire [24:0] base_last = long_base ? (LONG_CYC - 25'd1) : (SHORT_CYC - 25'd1);
	wire [2:0]  hard_at   = (timer_count == 3'h0) ? 3'h1 : timer_count;
	wire [2:0]  next_units = units + 3'h1;
	wire        tick = (base_cnt == base_last);
	wire        run  = wd_en & ~halt & ~fired;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			base_cnt   <= 25'h0;
			units      <= 3'h0;
			fired      <= 1'b0;
			hard_pulse <= 1'b0;
			soft_pulse <= 1'b0;
		end else begin
			hard_pulse <= 1'b0;
			soft_pulse <= 1'b0;
			if (kick || !wd_en) begin
				base_cnt <= 25'h0;
				units    <= 3'h0;
				fired    <= 1'b0;
			end else if (run) begin
				if (tick) begin
					base_cnt <= 25'h0;
					units    <= next_units;
					// alarm after timer_count base units, after one unit when timer_count is 0
					if (next_units >= hard_at) begin
						hard_pulse <= 1'b1;
						fired      <= 1'b1;
					end
					if (soft_sel && timer_count > 3'h1 && next_units == timer_count - 3'h1)
						soft_pulse <= 1'b1;
				end else begin
					base_cnt <= base_cnt + 25'h1;
				end
			end
		end
	end

endmodule // cwf_wdog

// ---- rtl/cwf_ctrl.v ----
/*
 control registers for watchdog and frequency programming of the clock
 generator. assumes an smbus slave engine outside that turns byte writes into
 reg_wr pulses, reads reg_rdata one cycle after presenting reg_addr, and
 pulses bus_stop on the stop condition. straps and pd_n are synchronous.
*/
`timescale 1ns/100ps
`include "cwf_regs.vh"
module cwf_ctrl #(
	parameter [24:0] WD_SHORT_CYC = `CWF_WD_SHORT_CYC,
	parameter [24:0] WD_LONG_CYC  = `CWF_WD_LONG_CYC
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        reset_n,
	// register byte port
	input  wire        reg_wr,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	input  wire        bus_stop,
	// straps, latched once after reset
	input  wire [2:0]  strap_frequency_select,
	input  wire [8:0]  strap_cpu_mult,
	input  wire        overclock_lock_strap,
	// power down, low while powered down
	input  wire        pd_n,
	// cpu pll control
	output reg  [2:0]  cpu_freq_select,
	output reg  [8:0]  cpu_mult,
	output reg  [1:0]  cpu_frac_thirds,
	output reg  [19:0] cpu_freq_khz,
	// src pll control
	output reg  [7:0]  src_mult,
	output reg  [19:0] src_freq_khz,
	// source selection
	output reg         src1_from_pll2,
	output reg         pci_from_pll2,
	output reg         n_prog_allowed,
	// watchdog status
	output reg         wd_hard_alarm,
	output reg         wd_soft_alarm
);

	// thirds of a step selected by the increment bits
	function [1:0] frac_of;
		input [1:0] ib;
		begin
			case (ib)
				2'b01:   frac_of = 2'd1;
				2'b10:   frac_of = 2'd2;
				default: frac_of = 2'd0;
			endcase
		end
	endfunction

	function [19:0] frac_khz;
		input [1:0] thirds;
		begin
			case (thirds)
				2'd1:    frac_khz = `CWF_FRAC1_KHZ;
				2'd2:    frac_khz = `CWF_FRAC2_KHZ;
				default: frac_khz = 20'd0;
			endcase
		end
	endfunction

	// registers
	reg        wd_en;
	reg        wd_soft_sel;
	reg        wd_long_base;
	reg  [2:0] wd_timer;
	reg        wd_reenable_after_powerdown;
	reg        cpu_fine_increment_hi;
	reg        cpu_fine_increment_lo;
	reg        cpu_multiplier_top_bit;
	reg  [7:0] cpu_multiplier_low;
	reg  [7:0] src_multiplier;
	reg        cpu_mode_sw;
	reg  [2:0] sw_freq_select;
	reg        n_prog_disable;
	reg        src1_pll2;
	reg        pci_pll2;
	// byte written to clock_source_select, held until the stop condition
	reg  [7:0] src_sel_pending;
	reg        src_sel_armed;
	// strap latch and power-down edge
	reg        straps_taken;
	reg  [2:0] strap_fs_latched;
	reg        pd_n_prev;

	wire       hard_pulse;
	wire       soft_pulse;
	wire       leave_pd = pd_n & ~pd_n_prev;
	wire       first    = ~straps_taken;
	wire       wr_wd    = reg_wr && (reg_addr == `CWF_OFS_WD_CTRL);
	wire       wr_fine  = reg_wr && (reg_addr == `CWF_OFS_FINE);
	wire       wr_cpul  = reg_wr && (reg_addr == `CWF_OFS_CPU_MULT_LO);
	wire       wr_src   = reg_wr && (reg_addr == `CWF_OFS_SRC_MULT);
	wire       wr_ssel  = reg_wr && (reg_addr == `CWF_OFS_SRC_SEL);
	wire       n_ok     = ~n_prog_disable;

	cwf_wdog #(
		.SHORT_CYC (WD_SHORT_CYC),
		.LONG_CYC  (WD_LONG_CYC)
	) u_wdog (
		.ref_clk     (ref_clk),
		.reset_n     (reset_n),
		.wd_en       (wd_en),
		.halt        (~pd_n),
		.kick        (reg_wr),
		.long_base   (wd_long_base),
		.soft_sel    (wd_soft_sel),
		.timer_count (wd_timer),
		.hard_pulse  (hard_pulse),
		.soft_pulse  (soft_pulse)
	);

	// strap capture just after reset release
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			straps_taken     <= 1'b0;
			strap_fs_latched <= 3'h0;
			pd_n_prev        <= 1'b1;
		end else begin
			straps_taken <= 1'b1;
			pd_n_prev    <= pd_n;
			if (first)
				strap_fs_latched <= strap_frequency_select;
		end
	end

	// watchdog_control
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wd_en         <= 1'b0;
			wd_soft_sel   <= 1'b0;
			wd_long_base  <= 1'b0;
			wd_timer      <= 3'h7;
			wd_hard_alarm <= 1'b0;
			wd_soft_alarm <= 1'b0;
		end else begin
			if (wr_wd) begin
				wd_en         <= reg_wdata[`CWF_WD_EN_BIT];
				wd_soft_sel   <= reg_wdata[`CWF_WD_SOFT_SEL_BIT];
				wd_long_base  <= reg_wdata[`CWF_WD_TBASE_BIT];
				wd_timer      <= reg_wdata[`CWF_WD_TIMER_MSB:0];
			end
			if (leave_pd && wd_reenable_after_powerdown)
				wd_en <= 1'b1;
			// a write of this byte clears the status; a new alarm wins
			if (hard_pulse)
				wd_hard_alarm <= 1'b1;
			else if (wr_wd)
				wd_hard_alarm <= 1'b0;
			if (soft_pulse)
				wd_soft_alarm <= 1'b1;
			else if (wr_wd)
				wd_soft_alarm <= 1'b0;
		end
	end

	// cpu_fine_and_wd_restore and multipliers
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wd_reenable_after_powerdown <= 1'b0;
			cpu_fine_increment_hi       <= 1'b0;
			cpu_fine_increment_lo       <= 1'b0;
			cpu_multiplier_top_bit      <= 1'b0;
			cpu_multiplier_low          <= 8'h00;
			src_multiplier              <= `CWF_SRC_MULT_RST;
		end else if (first) begin
			cpu_multiplier_top_bit <= strap_cpu_mult[8];
			cpu_multiplier_low     <= strap_cpu_mult[7:0];
		end else begin
			if (wr_fine) begin
				wd_reenable_after_powerdown <= reg_wdata[`CWF_FINE_REEN_BIT];
				cpu_fine_increment_hi       <= reg_wdata[`CWF_FINE_IB_HI_BIT];
				cpu_fine_increment_lo       <= reg_wdata[`CWF_FINE_IB_LO_BIT];
				if (n_ok)
					cpu_multiplier_top_bit <= reg_wdata[`CWF_FINE_TOP_BIT];
			end
			if (wr_cpul && n_ok)
				cpu_multiplier_low <= reg_wdata;
			if (wr_src && n_ok)
				src_multiplier <= reg_wdata;
		end
	end

	// clock_source_select, applied on the stop condition
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_mode_sw     <= 1'b0;
			sw_freq_select  <= 3'h0;
			n_prog_disable  <= 1'b0;
			src1_pll2       <= 1'b0;
			pci_pll2        <= 1'b0;
			src_sel_pending <= `CWF_SS_RST;
			src_sel_armed   <= 1'b0;
		end else if (first) begin
			sw_freq_select <= strap_frequency_select;
			n_prog_disable <= overclock_lock_strap;
		end else begin
			if (wr_ssel) begin
				src_sel_pending <= reg_wdata;
				src_sel_armed   <= 1'b1;
			end else if (bus_stop) begin
				src_sel_armed <= 1'b0;
			end
			if (bus_stop && src_sel_armed) begin
				cpu_mode_sw    <= src_sel_pending[`CWF_SS_MODE_BIT];
				sw_freq_select <= src_sel_pending[`CWF_SS_SFS_MSB:`CWF_SS_SFS_LSB];
				n_prog_disable <= src_sel_pending[`CWF_SS_NDIS_BIT];
				src1_pll2      <= src_sel_pending[`CWF_SS_SRC1_BIT];
				pci_pll2       <= src_sel_pending[`CWF_SS_PCI_BIT];
			end
			// the alarm overrides a mode applied by a stop in the same cycle
			if (hard_pulse)
				cpu_mode_sw <= 1'b0;
		end
	end

	// pll controls, registered from the register state
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_freq_select <= 3'h0;
			cpu_mult        <= 9'h000;
			cpu_frac_thirds <= 2'd0;
			cpu_freq_khz    <= 20'd0;
			src_mult        <= `CWF_SRC_MULT_RST;
			src_freq_khz    <= 20'd0;
			src1_from_pll2  <= 1'b0;
			pci_from_pll2   <= 1'b0;
			n_prog_allowed  <= 1'b0;
		end else begin
			if (cpu_mode_sw && !hard_pulse)
				cpu_freq_select <= sw_freq_select;
			else
				cpu_freq_select <= strap_fs_latched;
			cpu_mult        <= {cpu_multiplier_top_bit, cpu_multiplier_low};
			cpu_frac_thirds <= frac_of({cpu_fine_increment_hi, cpu_fine_increment_lo});
			cpu_freq_khz    <= {11'h000, cpu_multiplier_top_bit, cpu_multiplier_low}
				* `CWF_CPU_RES_KHZ
				+ frac_khz(frac_of({cpu_fine_increment_hi, cpu_fine_increment_lo}));
			src_mult        <= src_multiplier;
			src_freq_khz    <= {12'h000, src_multiplier} * `CWF_SRC_RES_KHZ;
			src1_from_pll2  <= src1_pll2;
			pci_from_pll2   <= pci_pll2;
			n_prog_allowed  <= ~n_prog_disable;
		end
	end

	// read data, one cycle after the address
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`CWF_OFS_WD_CTRL:
					reg_rdata <= {wd_en, wd_soft_sel, wd_hard_alarm, wd_soft_alarm,
						wd_long_base, wd_timer};
				`CWF_OFS_FINE:
					reg_rdata <= {wd_reenable_after_powerdown, 4'h0, cpu_fine_increment_hi,
						cpu_fine_increment_lo, cpu_multiplier_top_bit};
				`CWF_OFS_CPU_MULT_LO:
					reg_rdata <= cpu_multiplier_low;
				`CWF_OFS_SRC_MULT:
					reg_rdata <= src_multiplier;
				`CWF_OFS_SRC_SEL:
					reg_rdata <= {cpu_mode_sw, sw_freq_select, n_prog_disable,
						src1_pll2, pci_pll2, 1'b0};
				default:
					reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule // cwf_ctrl

// ---- dv/cwf_ctrl_sva.sv ----
/*
 port checker for cwf_ctrl.
 assumes straps stay constant while running.
*/
`timescale 1ns/100ps
module cwf_ctrl_sva #(
	parameter [24:0] WD_SHORT_CYC = 25'd20,
	parameter [24:0] WD_LONG_CYC  = 25'd80
) (
	// clock, reset and bus
	input wire        ref_clk,
	input wire        reset_n,
	input wire        reg_wr,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        bus_stop,
	input wire [2:0]  strap_frequency_select,
	// outputs watched
	input wire [2:0]  cpu_freq_select,
	input wire [8:0]  cpu_mult,
	input wire [1:0]  cpu_frac_thirds,
	input wire [19:0] cpu_freq_khz,
	input wire [7:0]  src_mult,
	input wire [19:0] src_freq_khz,
	input wire        src1_from_pll2,
	input wire        pci_from_pll2,
	input wire        n_prog_allowed,
	input wire        wd_hard_alarm
);
	wire       wr_wd = reg_wr && reg_addr == 8'h0f;
	wire       wr_lo = reg_wr && reg_addr == 8'h11;
	wire       wr_fn = reg_wr && reg_addr == 8'h10;
	wire [1:0] thirds = (reg_wdata[2:1] == 2'b01) ? 2'd1 : (reg_wdata[2:1] == 2'b10) ? 2'd2 : 2'd0;
	reg  [18:0] prev;
	reg  [1:0]  quiet;
	// counts cycles with multipliers unchanged, so lagging products settle
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev  <= 19'h0;
			quiet <= 2'd0;
		end else begin
			prev <= {cpu_mult, cpu_frac_thirds, src_mult};
			if (prev != {cpu_mult, cpu_frac_thirds, src_mult})
				quiet <= 2'd0;
			else if (quiet != 2'd3)
				quiet <= quiet + 2'd1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	src_freq_a: assert property (quiet[1] |-> src_freq_khz == src_mult * 20'd500)
		else $error("src frequency does not match multiplier");
	cpu_freq_a: assert property (quiet[1] |-> cpu_freq_khz == cpu_mult * 20'd1000 +
		(cpu_frac_thirds == 2'd1 ? 20'd333 : cpu_frac_thirds == 2'd2 ? 20'd666 : 20'd0))
		else $error("cpu frequency does not match multiplier");
	fine_step_a: assert property (wr_fn |-> ##2 cpu_frac_thirds == $past(thirds, 2))
		else $error("increment bits mapped wrongly");
	hard_strap_a: assert property ($rose(wd_hard_alarm) |-> cpu_freq_select == strap_frequency_select)
		else $error("hard alarm did not restore strap select");
	stop_apply_a: assert property (($changed(src1_from_pll2) || $changed(pci_from_pll2) ||
		$changed(n_prog_allowed)) && $past(reset_n, 3) |-> $past(bus_stop, 2))
		else $error("source byte applied without stop");
	// n_prog_allowed lags the enable by one cycle, so skip the edge after a stop
	mult_block_a: assert property (!n_prog_allowed && wr_lo && !bus_stop && !$past(bus_stop) |->
		##2 cpu_mult == $past(cpu_mult, 2))
		else $error("multiplier written while blocked");
	mult_load_a: assert property (n_prog_allowed && wr_lo && !$past(bus_stop) |->
		##2 cpu_mult[7:0] == $past(reg_wdata, 2))
		else $error("multiplier write not applied");
	alarm_sticky_a: assert property (wd_hard_alarm && !wr_wd && !$past(wr_wd) |=> wd_hard_alarm)
		else $error("hard alarm status dropped");
	cover property ($rose(wd_hard_alarm));
	cover property (bus_stop ##2 $changed(pci_from_pll2));
	cover property (!n_prog_allowed && wr_lo);
endmodule // cwf_ctrl_sva

bind cwf_ctrl cwf_ctrl_sva #(.WD_SHORT_CYC(WD_SHORT_CYC), .WD_LONG_CYC(WD_LONG_CYC)) chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .bus_stop(bus_stop), .strap_frequency_select(strap_frequency_select),
	.cpu_freq_select(cpu_freq_select), .cpu_mult(cpu_mult), .cpu_frac_thirds(cpu_frac_thirds),
	.cpu_freq_khz(cpu_freq_khz), .src_mult(src_mult), .src_freq_khz(src_freq_khz),
	.src1_from_pll2(src1_from_pll2), .pci_from_pll2(pci_from_pll2),
	.n_prog_allowed(n_prog_allowed), .wd_hard_alarm(wd_hard_alarm));

// ---- dv/cwf_host.sv ----
/*
 bus host model feeding the register byte port.
 assumes ref_clk from the bench; drives on the falling edge.
*/
`timescale 1ns/100ps
module cwf_host (
	// clock and read data
	input wire       ref_clk,
	input wire [7:0] reg_rdata,
	// byte port drive
	output reg       reg_wr,
	output reg [7:0] reg_addr,
	output reg [7:0] reg_wdata,
	output reg       bus_stop
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		bus_stop = 1'b0;
	end
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge ref_clk);
			reg_wr = 1'b1;
			reg_addr = a;
			reg_wdata = d;
			@(negedge ref_clk);
			reg_wr = 1'b0;
			reg_wdata = ~d;
		end
	endtask
	// stop ends the transaction and lets the source byte apply
	task stop;
		begin
			@(negedge ref_clk);
			bus_stop = 1'b1;
			@(negedge ref_clk);
			bus_stop = 1'b0;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(negedge ref_clk);
			reg_addr = a;
			@(negedge ref_clk);
			@(negedge ref_clk);
			d = reg_rdata;
		end
	endtask
endmodule // cwf_host

// ---- dv/clock_watchdog_freq_program_bench.sv ----
/*
 self-checking bench for cwf_ctrl with short watchdog bases.
 assumes cwf_host drives the byte port.
*/
`timescale 1ns/100ps
module clock_watchdog_freq_program_bench;
	reg         ref_clk, reset_n, pd_n;
	wire        reg_wr, bus_stop, src1_from_pll2, pci_from_pll2, n_prog_allowed;
	wire        wd_hard_alarm, wd_soft_alarm;
	wire [7:0]  reg_addr, reg_wdata, reg_rdata, src_mult;
	wire [2:0]  cpu_freq_select;
	wire [8:0]  cpu_mult;
	wire [1:0]  cpu_frac_thirds;
	wire [19:0] cpu_freq_khz, src_freq_khz;
	integer     n_mismatch, n_tests, i, n;
	reg  [7:0]  rd;
	reg  [63:0] rows [0:6];
	cwf_ctrl #(.WD_SHORT_CYC(25'd20), .WD_LONG_CYC(25'd80)) uut (
		.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_stop(bus_stop),
		.strap_frequency_select(3'h5), .strap_cpu_mult(9'h0c8), .overclock_lock_strap(1'b0),
		.pd_n(pd_n), .cpu_freq_select(cpu_freq_select), .cpu_mult(cpu_mult),
		.cpu_frac_thirds(cpu_frac_thirds), .cpu_freq_khz(cpu_freq_khz), .src_mult(src_mult),
		.src_freq_khz(src_freq_khz), .src1_from_pll2(src1_from_pll2),
		.pci_from_pll2(pci_from_pll2), .n_prog_allowed(n_prog_allowed),
		.wd_hard_alarm(wd_hard_alarm), .wd_soft_alarm(wd_soft_alarm));
	cwf_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .bus_stop(bus_stop));
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task summarize;
		begin
			if (n_mismatch == 0 && n_tests > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task wait_hard;
		begin
			n = 0;
			while (wd_hard_alarm !== 1'b1 && n < 200) begin
				@(negedge ref_clk);
				n = n + 1;
			end
		end
	endtask
	task do_reset;
		begin
			reset_n = 1'b0;
			repeat (3) @(negedge ref_clk);
			reset_n = 1'b1;
			repeat (3) @(negedge ref_clk);
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#(40 * 5000);
		n_mismatch = n_mismatch + 1;
		summarize;
	end
	initial begin
		n_mismatch = 0;
		n_tests = 0;
		pd_n = 1'b1;
		// addr, write data, read back, cpu khz, src khz
		rows[0] = {8'h11, 8'h64, 8'h64, 20'h186a0, 20'h186a0};
		rows[1] = {8'h10, 8'h02, 8'h02, 20'h187ed, 20'h186a0};
		rows[2] = {8'h10, 8'h04, 8'h04, 20'h1893a, 20'h186a0};
		rows[3] = {8'h10, 8'h7f, 8'h07, 20'h56ea0, 20'h186a0};
		rows[4] = {8'h10, 8'h00, 8'h00, 20'h186a0, 20'h186a0};
		rows[5] = {8'h12, 8'h64, 8'h64, 20'h186a0, 20'h0c350};
		rows[6] = {8'h20, 8'h5a, 8'h00, 20'h186a0, 20'h0c350};
		do_reset;
		host.rd(8'h0f, rd); chk(rd, 8'h07);
		host.rd(8'h10, rd); chk(rd, 8'h00);
		host.rd(8'h11, rd); chk(rd, 8'hc8);
		host.rd(8'h13, rd); chk(rd, 8'h50);
		chk(cpu_freq_khz, 20'h30d40);
		chk(src_freq_khz, 20'h186a0);
		chk(n_prog_allowed, 1'b1);
		for (i = 0; i < 7; i = i + 1) begin
			host.wr(rows[i][63:56], rows[i][55:48]);
			host.rd(rows[i][63:56], rd);
			chk(rd, rows[i][47:40]);
			chk(cpu_freq_khz, rows[i][39:20]);
			chk(src_freq_khz, rows[i][19:0]);
		end
		host.wr(8'h13, 8'h86);
		repeat (4) @(negedge ref_clk);
		chk(pci_from_pll2, 1'b0);
		host.stop;
		repeat (3) @(negedge ref_clk);
		chk({cpu_freq_select, src1_from_pll2, pci_from_pll2}, 5'h03);
		host.wr(8'h13, 8'h8e);
		host.stop;
		repeat (3) @(negedge ref_clk);
		chk(n_prog_allowed, 1'b0);
		host.wr(8'h11, 8'h33);
		host.rd(8'h11, rd); chk(rd, 8'h64);
		host.wr(8'h13, 8'h80);
		host.stop;
		host.wr(8'h0f, 8'h01);
		repeat (60) @(negedge ref_clk);
		chk(wd_hard_alarm, 1'b0);
		host.wr(8'h0f, 8'hc2);
		wait_hard;
		chk(n >= 38 && n <= 46, 1);
		chk({wd_hard_alarm, wd_soft_alarm, cpu_freq_select}, 5'h1d);
		host.rd(8'h13, rd); chk(rd, 8'h00);
		host.wr(8'h0f, 8'h89);
		wait_hard;
		chk(n >= 78 && n <= 86, 1);
		host.wr(8'h0f, 8'h01);
		host.wr(8'h10, 8'h80);
		pd_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		pd_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		host.rd(8'h0f, rd); chk(rd, 8'h81);
		do_reset;
		host.rd(8'h0f, rd); chk(rd, 8'h07);
		chk(src_mult, 8'hc8);
		summarize;
	end
endmodule // clock_watchdog_freq_program_bench
